// [rtl/cpu_store_bit_flag_ops.v]
// execution unit for stores, loads, i/o, stack, shifts, bits and flags
//
// The implementer's own choices: register access over APB and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "exec_unit_defs.vh"
// How it works
// - store at pointer, then pointer plus one
// - pointer minus one, then store there
// - store at pointer plus displacement, unchanged
// - program byte into rd or r0, three cycles
// - i/o read and write, one cycle
// - push one cycle, pop two cycles
// - shifts fill zero or keep sign, set flags
// - rotate left through carry, flags with half
// - rotate right through carry, no half flag
// - force one i/o bit to one
// - force one i/o bit to zero
// - copy register bit into transfer flag
// - copy transfer flag into register bit
// - flag set or clear touches one bit
// - break, sleep, watchdog: one cycle pulses; idle gives none
// - nonvolatile store route adds at least one wait; push and pop never wait
// - stall until nonvolatile store completes
module cpu_store_bit_flag_ops #(
  parameter ADDR_W = 16,
  parameter [15:0] SLOW_BASE = `SLOW_BASE,
  parameter [15:0] SP_INIT = `SP_RESET
) (
  input wire clk,
  input wire rst_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire instr_valid,
  output wire instr_ready,
  input wire [4:0] instr_op,
  input wire [4:0] instr_rd,
  input wire [5:0] instr_imm,
  input wire [2:0] instr_bit,
  output reg mem_req,
  output reg mem_we,
  output reg [ADDR_W-1:0] mem_addr,
  output reg [7:0] mem_wdata,
  input wire [7:0] mem_rdata,
  input wire mem_slow_done,
  output reg pm_req,
  output reg [15:0] pm_addr,
  input wire [7:0] pm_rdata,
  output wire [5:0] io_rd_addr,
  input wire [7:0] io_rdata,
  output reg io_we,
  output reg [5:0] io_wr_addr,
  output reg [7:0] io_wdata,
  output reg break_pulse,
  output reg sleep_pulse,
  output reg wdog_pulse,
  output wire irq_enable
);
  // states
  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_SLOW_WAIT = 3'h1;
  localparam [2:0] S_PM_WAIT = 3'h2;
  localparam [2:0] S_PM_TAKE = 3'h3;
  localparam [2:0] S_POP_TAKE = 3'h4;

  reg rst_meta_reg; // reset release, first stage
  reg rst_sync_reg; // reset release, second stage
  wire rst_n_int; // internal reset copy
  reg [2:0] state_reg; // sequencer state
  reg [2:0] state_next;
  reg run_reg; // software run enable
  reg [7:0] flags_reg; // status_flags_register
  reg [7:0] flags_next;
  reg [15:0] sp_reg; // stack pointer
  reg [15:0] sp_next;
  reg [4:0] dest_reg; // pending destination register
  reg [4:0] dest_next;
  reg pm_inc_reg; // pending pointer bump after program load
  reg pm_inc_next;
  reg mem_req_next;
  reg mem_we_next;
  reg [ADDR_W-1:0] mem_addr_next;
  reg [7:0] mem_wdata_next;
  reg pm_req_next;
  reg [15:0] pm_addr_next;
  reg io_we_next;
  reg [5:0] io_wr_addr_next;
  reg [7:0] io_wdata_next;
  reg break_next;
  reg sleep_next;
  reg wdog_next;
  reg rf_we; // register byte write
  reg [4:0] rf_waddr;
  reg [7:0] rf_wdata;
  reg z_we; // pointer pair write
  reg [15:0] z_wdata;
  wire [7:0] rf_rdata; // operand byte
  wire [15:0] z_ptr; // pointer pair value
  wire accept; // instruction taken this cycle
  wire [7:0] io_value; // i/o read with write forwarding
  reg [7:0] sh_res; // shift or rotate result
  reg sh_carry; // carry out of shift
  reg [15:0] store_addr; // computed store address
  wire apb_wr; // apb write strobe
  wire apb_hit; // mapped apb address

  // reset released through two flops
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end
  assign rst_n_int = rst_sync_reg;

  // register file
  gp_regfile #(
    .DEPTH(32)
  ) u_regfile (
    .clk(clk),
    .rd_addr(instr_rd),
    .rd_data(rf_rdata),
    .wr_en(rf_we),
    .wr_addr(rf_waddr),
    .wr_data(rf_wdata),
    .z_wr_en(z_we),
    .z_wr_data(z_wdata),
    .z_data(z_ptr)
  );

  // handshake: only idle and enabled takes new work
  assign instr_ready = (state_reg == S_IDLE) && run_reg;
  assign accept = instr_valid && instr_ready;
  assign irq_enable = flags_reg[`FLAG_I];

  // i/o read address straight from the instruction
  assign io_rd_addr = instr_imm;
  // a write still in flight is seen by the next read
  assign io_value = (io_we && (io_wr_addr == instr_imm)) ? io_wdata : io_rdata;

  // shift and rotate datapath
  always @* begin
    sh_res = rf_rdata;
    sh_carry = flags_reg[`FLAG_C];
    case (instr_op)
      `OP_SHL: begin
        sh_res = {rf_rdata[6:0], 1'b0};
        sh_carry = rf_rdata[7];
      end
      `OP_SHR: begin
        sh_res = {1'b0, rf_rdata[7:1]};
        sh_carry = rf_rdata[0];
      end
      `OP_SHRA: begin
        sh_res = {rf_rdata[7], rf_rdata[7:1]};
        sh_carry = rf_rdata[0];
      end
      `OP_RCL: begin
        sh_res = {rf_rdata[6:0], flags_reg[`FLAG_C]};
        sh_carry = rf_rdata[7];
      end
      `OP_RCR: begin
        sh_res = {flags_reg[`FLAG_C], rf_rdata[7:1]};
        sh_carry = rf_rdata[0];
      end
      default: begin
        sh_res = rf_rdata;
      end
    endcase
  end

  // store address per pointer mode
  always @* begin
    case (instr_op)
      `OP_STORE_ZDEC: store_addr = z_ptr - 16'h0001;
      `OP_STORE_ZDISP: store_addr = z_ptr + {10'h000, instr_imm};
      default: store_addr = z_ptr;
    endcase
  end

  // main sequencer and execution decode
  always @* begin
    state_next = state_reg;
    flags_next = flags_reg;
    sp_next = sp_reg;
    dest_next = dest_reg;
    pm_inc_next = pm_inc_reg;
    mem_req_next = 1'b0;
    mem_we_next = mem_we;
    mem_addr_next = mem_addr;
    mem_wdata_next = mem_wdata;
    pm_req_next = 1'b0;
    pm_addr_next = pm_addr;
    io_we_next = 1'b0;
    io_wr_addr_next = io_wr_addr;
    io_wdata_next = io_wdata;
    break_next = 1'b0;
    sleep_next = 1'b0;
    wdog_next = 1'b0;
    rf_we = 1'b0;
    rf_waddr = instr_rd;
    rf_wdata = rf_rdata;
    z_we = 1'b0;
    z_wdata = z_ptr;
    case (state_reg)
      S_IDLE: begin
        if (accept) begin
          case (instr_op)
            `OP_STORE_Z, `OP_STORE_ZINC, `OP_STORE_ZDEC,
            `OP_STORE_ZDISP: begin
              mem_req_next = 1'b1;
              mem_we_next = 1'b1;
              mem_addr_next = store_addr[ADDR_W-1:0];
              mem_wdata_next = rf_rdata;
              if (instr_op == `OP_STORE_ZINC) begin
                z_we = 1'b1;
                z_wdata = z_ptr + 16'h0001;
              end
              if (instr_op == `OP_STORE_ZDEC) begin
                z_we = 1'b1;
                z_wdata = store_addr;
              end
              // nonvolatile route holds the core in a wait
              if (store_addr >= SLOW_BASE) begin
                state_next = S_SLOW_WAIT;
              end
            end
            `OP_PM_R0, `OP_PM_RD, `OP_PM_INC: begin
              pm_req_next = 1'b1;
              pm_addr_next = z_ptr;
              dest_next = (instr_op == `OP_PM_R0) ? `R0_INDEX : instr_rd;
              pm_inc_next = (instr_op == `OP_PM_INC);
              state_next = S_PM_WAIT;
            end
            `OP_IO_IN: begin
              rf_we = 1'b1;
              rf_wdata = io_value;
            end
            `OP_IO_OUT: begin
              io_we_next = 1'b1;
              io_wr_addr_next = instr_imm;
              io_wdata_next = rf_rdata;
            end
            `OP_PUSH: begin
              mem_req_next = 1'b1;
              mem_we_next = 1'b1;
              mem_addr_next = sp_reg[ADDR_W-1:0];
              mem_wdata_next = rf_rdata;
              sp_next = sp_reg - 16'h0001;
            end
            `OP_POP: begin
              mem_req_next = 1'b1;
              mem_we_next = 1'b0;
              sp_next = sp_reg + 16'h0001;
              mem_addr_next = sp_next[ADDR_W-1:0];
              dest_next = instr_rd;
              state_next = S_POP_TAKE;
            end
            `OP_SHL, `OP_SHR, `OP_SHRA, `OP_RCL, `OP_RCR: begin
              rf_we = 1'b1;
              rf_wdata = sh_res;
              flags_next[`FLAG_C] = sh_carry;
              flags_next[`FLAG_Z] = (sh_res == 8'h00);
              flags_next[`FLAG_N] = sh_res[7];
              flags_next[`FLAG_V] = sh_res[7] ^ sh_carry;
              // half carry only on the left-going ops
              if (instr_op == `OP_SHL || instr_op == `OP_RCL) begin
                flags_next[`FLAG_H] = rf_rdata[3];
              end
            end
            `OP_SWAP: begin
              rf_we = 1'b1;
              rf_wdata = {rf_rdata[3:0], rf_rdata[7:4]};
            end
            `OP_IO_SET: begin
              io_we_next = 1'b1;
              io_wr_addr_next = instr_imm;
              io_wdata_next = io_value | (8'h01 << instr_bit);
            end
            `OP_IO_CLR: begin
              io_we_next = 1'b1;
              io_wr_addr_next = instr_imm;
              io_wdata_next = io_value & ~(8'h01 << instr_bit);
            end
            `OP_BIT_TO_T: begin
              flags_next[`FLAG_T] = rf_rdata[instr_bit];
            end
            `OP_T_TO_BIT: begin
              rf_we = 1'b1;
              rf_wdata = rf_rdata;
              rf_wdata[instr_bit] = flags_reg[`FLAG_T];
            end
            `OP_FLAG_SET: begin
              flags_next[instr_bit] = 1'b1;
            end
            `OP_FLAG_CLR: begin
              flags_next[instr_bit] = 1'b0;
            end
            `OP_BREAK: begin
              break_next = 1'b1;
            end
            `OP_SLEEP: begin
              sleep_next = 1'b1;
            end
            `OP_WDOG: begin
              wdog_next = 1'b1;
            end
            default: begin
              state_next = S_IDLE; // idle op and unknown codes
            end
          endcase
        end
      end
      S_SLOW_WAIT: begin
        // request held until the controller reports done
        mem_req_next = 1'b1;
        if (mem_slow_done) begin
          mem_req_next = 1'b0;
          state_next = S_IDLE;
        end
      end
      S_PM_WAIT: begin
        state_next = S_PM_TAKE; // program memory latency
      end
      S_PM_TAKE: begin
        rf_we = 1'b1;
        rf_waddr = dest_reg;
        rf_wdata = pm_rdata;
        if (pm_inc_reg) begin
          z_we = 1'b1;
          z_wdata = pm_addr + 16'h0001;
        end
        state_next = S_IDLE;
      end
      S_POP_TAKE: begin
        rf_we = 1'b1;
        rf_waddr = dest_reg;
        rf_wdata = mem_rdata;
        state_next = S_IDLE;
      end
      default: begin
        state_next = S_IDLE;
      end
    endcase
  end

  // apb slave, no wait states
  assign pready = 1'b1;
  assign apb_hit = (paddr == `ADDR_CTRL) || (paddr == `ADDR_FLAGS) ||
                   (paddr == `ADDR_SP) || (paddr == `ADDR_STATE);
  assign pslverr = psel && penable && !apb_hit;
  assign apb_wr = psel && penable && pwrite;

  // read mux
  always @* begin
    case (paddr)
      `ADDR_CTRL: prdata = {31'h00000000, run_reg};
      `ADDR_FLAGS: prdata = {24'h000000, flags_reg};
      `ADDR_SP: prdata = {16'h0000, sp_reg};
      `ADDR_STATE: prdata = {z_ptr, 13'h0000, state_reg};
      default: prdata = 32'h00000000;
    endcase
  end

  // state and outputs
  always @(posedge clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      state_reg <= S_IDLE;
      run_reg <= `CTRL_RESET;
      flags_reg <= `FLAGS_RESET;
      sp_reg <= SP_INIT;
      dest_reg <= 5'h00;
      pm_inc_reg <= 1'b0;
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_addr <= {ADDR_W{1'b0}};
      mem_wdata <= 8'h00;
      pm_req <= 1'b0;
      pm_addr <= 16'h0000;
      io_we <= 1'b0;
      io_wr_addr <= 6'h00;
      io_wdata <= 8'h00;
      break_pulse <= 1'b0;
      sleep_pulse <= 1'b0;
      wdog_pulse <= 1'b0;
    end else begin
      state_reg <= state_next;
      dest_reg <= dest_next;
      pm_inc_reg <= pm_inc_next;
      mem_req <= mem_req_next;
      mem_we <= mem_we_next;
      mem_addr <= mem_addr_next;
      mem_wdata <= mem_wdata_next;
      pm_req <= pm_req_next;
      pm_addr <= pm_addr_next;
      io_we <= io_we_next;
      io_wr_addr <= io_wr_addr_next;
      io_wdata <= io_wdata_next;
      break_pulse <= break_next;
      sleep_pulse <= sleep_next;
      wdog_pulse <= wdog_next;
      // software writes; an op that changes flags or sp wins the same cycle
      if (apb_wr && paddr == `ADDR_CTRL) begin
        run_reg <= pwdata[0];
      end
      if (apb_wr && paddr == `ADDR_FLAGS && flags_next == flags_reg) begin
        flags_reg <= pwdata[7:0];
      end else begin
        flags_reg <= flags_next;
      end
      if (apb_wr && paddr == `ADDR_SP && sp_next == sp_reg) begin
        sp_reg <= pwdata[15:0];
      end else begin
        sp_reg <= sp_next;
      end
    end
  end
endmodule // cpu_store_bit_flag_ops
`default_nettype wire

// [rtl/exec_unit_defs.vh]
// constants shared by the execution unit and its register file
`ifndef EXEC_UNIT_DEFS_VH
`define EXEC_UNIT_DEFS_VH

// operation codes on instr_op
`define OP_W 5
`define OP_IDLE 5'h00
`define OP_STORE_Z 5'h01
`define OP_STORE_ZINC 5'h02
`define OP_STORE_ZDEC 5'h03
`define OP_STORE_ZDISP 5'h04
`define OP_PM_R0 5'h05
`define OP_PM_RD 5'h06
`define OP_PM_INC 5'h07
`define OP_IO_IN 5'h08
`define OP_IO_OUT 5'h09
`define OP_PUSH 5'h0a
`define OP_POP 5'h0b
`define OP_SHL 5'h0c
`define OP_SHR 5'h0d
`define OP_SHRA 5'h0e
`define OP_RCL 5'h0f
`define OP_RCR 5'h10
`define OP_SWAP 5'h11
`define OP_IO_SET 5'h12
`define OP_IO_CLR 5'h13
`define OP_BIT_TO_T 5'h14
`define OP_T_TO_BIT 5'h15
`define OP_FLAG_SET 5'h16
`define OP_FLAG_CLR 5'h17
`define OP_BREAK 5'h18
`define OP_SLEEP 5'h19
`define OP_WDOG 5'h1a

// status flag positions
`define FLAG_C 0
`define FLAG_Z 1
`define FLAG_N 2
`define FLAG_V 3
`define FLAG_S 4
`define FLAG_H 5
`define FLAG_T 6
`define FLAG_I 7

// pointer pair and default operand
`define ZLO_INDEX 5'h1e
`define R0_INDEX 5'h00

// apb register byte offsets
`define ADDR_CTRL 8'h00
`define ADDR_FLAGS 8'h04
`define ADDR_SP 8'h08
`define ADDR_STATE 8'h0c

// reset values and nonvolatile route base
`define CTRL_RESET 1'b0
`define FLAGS_RESET 8'h00
`define SP_RESET 16'h03ff
`define SLOW_BASE 16'h1000

`endif

// [rtl/gp_regfile.v]
// thirty-two byte general register file with pointer pair port
`timescale 1ns/100ps
`default_nettype none
module gp_regfile #(
  parameter DEPTH = 32
) (
  input wire clk,
  input wire [4:0] rd_addr,
  output wire [7:0] rd_data,
  input wire wr_en,
  input wire [4:0] wr_addr,
  input wire [7:0] wr_data,
  input wire z_wr_en,
  input wire [15:0] z_wr_data,
  output wire [15:0] z_data
);
  reg [7:0] mem_reg [0:DEPTH-1]; // register bytes

  // read is immediate so single-cycle ops see operands at once
  assign rd_data = mem_reg[rd_addr];
  assign z_data = {mem_reg[`ZLO_INDEX + 5'h01], mem_reg[`ZLO_INDEX]};

  // byte write, pointer pair write wins on overlap
  always @(posedge clk) begin
    if (wr_en) begin
      mem_reg[wr_addr] <= wr_data;
    end
    if (z_wr_en) begin
      mem_reg[`ZLO_INDEX] <= z_wr_data[7:0];
      mem_reg[`ZLO_INDEX + 5'h01] <= z_wr_data[15:8];
    end
  end
endmodule // gp_regfile
`default_nettype wire

// [tb/cpu_store_bit_flag_ops_chk.sv]
// port assertions for the execution unit
`timescale 1ns/100ps
`default_nettype none
`include "exec_unit_defs.vh"
module cpu_store_bit_flag_ops_chk #(
  parameter ADDR_W = 16,
  parameter [15:0] SLOW_BASE = 16'h1000
) (
  input wire clk,
  input wire rst_n,
  input wire instr_valid,
  input wire instr_ready,
  input wire [4:0] instr_op,
  input wire [5:0] instr_imm,
  input wire [2:0] instr_bit,
  input wire mem_req,
  input wire mem_we,
  input wire [ADDR_W-1:0] mem_addr,
  input wire mem_slow_done,
  input wire pm_req,
  input wire [7:0] io_rdata,
  input wire io_we,
  input wire [5:0] io_wr_addr,
  input wire [7:0] io_wdata,
  input wire break_pulse,
  input wire sleep_pulse,
  input wire wdog_pulse,
  input wire irq_enable
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire acc = instr_valid && instr_ready; // instruction taken
  wire sto = instr_op inside {[`OP_STORE_Z:`OP_STORE_ZDISP]}; // stores
  wire pm = instr_op inside {[`OP_PM_R0:`OP_PM_INC]}; // program loads
  wire nvw = mem_req && mem_we && mem_addr >= SLOW_BASE; // slow write
  a_store_issue: assert property (
    acc && sto |=> mem_req && mem_we) else $error("store not issued");
  a_ram_store_fast: assert property (
    acc && sto ##1 mem_addr < SLOW_BASE |-> instr_ready)
    else $error("ram store slow");
  a_slow_wait: assert property (
    $rose(nvw) |-> !instr_ready) else $error("slow store no wait");
  a_slow_stall: assert property (
    nvw && !mem_slow_done |=> nvw && !instr_ready && $stable(mem_addr))
    else $error("slow stall broken");
  a_slow_end: assert property (
    nvw && mem_slow_done |=> !mem_req && instr_ready)
    else $error("slow end late");
  a_pm_three: assert property (
    acc && pm |=> pm_req && !instr_ready ##1 !instr_ready ##1 instr_ready)
    else $error("program load timing");
  a_pop_two: assert property (
    acc && instr_op == `OP_POP |=> mem_req && !mem_we && !instr_ready
    ##1 instr_ready) else $error("pop timing");
  a_push_one: assert property (
    acc && instr_op == `OP_PUSH |=> mem_req && mem_we && instr_ready)
    else $error("push timing");
  a_io_out: assert property (
    acc && instr_op == `OP_IO_OUT |=> io_we && io_wr_addr == $past(instr_imm))
    else $error("io write");
  a_io_set: assert property (
    acc && instr_op == `OP_IO_SET |=> io_we
    && io_wdata == ($past(io_rdata) | (8'h01 << $past(instr_bit))))
    else $error("io bit set");
  a_io_clr: assert property (
    acc && instr_op == `OP_IO_CLR |=> io_we
    && io_wdata == ($past(io_rdata) & ~(8'h01 << $past(instr_bit))))
    else $error("io bit clear");
  a_ctl_pulse: assert property (
    acc && instr_op == `OP_BREAK |=> break_pulse && !sleep_pulse && !wdog_pulse)
    else $error("break pulse");
  a_irq_flag: assert property (
    acc && instr_op inside {`OP_FLAG_SET, `OP_FLAG_CLR} && instr_bit == 3'h7
    |=> irq_enable == ($past(instr_op) == `OP_FLAG_SET))
    else $error("irq flag");
  a_one_cycle: assert property (
    acc && instr_op inside {[`OP_SHL:`OP_WDOG]} |=> instr_ready)
    else $error("single cycle op slow");
  c_pm: cover property (acc && pm);
  c_pop: cover property (acc && instr_op == `OP_POP);
  c_slow: cover property (nvw ##1 nvw ##1 nvw);
endmodule // cpu_store_bit_flag_ops_chk
bind cpu_store_bit_flag_ops cpu_store_bit_flag_ops_chk #(
  .ADDR_W(ADDR_W), .SLOW_BASE(SLOW_BASE)) u_chk (.clk, .rst_n,
  .instr_valid, .instr_ready, .instr_op, .instr_imm, .instr_bit, .mem_req,
  .mem_we, .mem_addr, .mem_slow_done, .pm_req, .io_rdata, .io_we,
  .io_wr_addr, .io_wdata, .break_pulse, .sleep_pulse, .wdog_pulse,
  .irq_enable);
`default_nettype wire

// [tb/exec_mem_model.sv]
// data, program and i/o memory model behind the execution unit
`timescale 1ns/100ps
`default_nettype none
module exec_mem_model #(
  parameter [15:0] SLOW_BASE = 16'h1000
) (
  input wire logic clk,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [15:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  output logic [7:0] mem_rdata,
  output logic mem_slow_done,
  input wire logic pm_req,
  input wire logic [15:0] pm_addr,
  output logic [7:0] pm_rdata,
  input wire logic [5:0] io_rd_addr,
  output logic [7:0] io_rdata,
  input wire logic io_we,
  input wire logic [5:0] io_wr_addr,
  input wire logic [7:0] io_wdata,
  input wire logic [3:0] slow_wait
);
  logic [7:0] mem [0:65535]; // data space
  logic [7:0] io [0:63]; // i/o space
  logic [7:0] junk = 8'h5a; // shown outside valid windows
  logic [7:0] pm_q = 8'h00; // synchronous program byte
  logic pm_ok = 1'b0; // program byte valid this cycle
  logic [3:0] wcnt = 4'h0; // cycles spent in slow access
  wire slow = mem_req && mem_addr >= SLOW_BASE; // slow route
  // grant only after the commanded number of waits
  assign mem_slow_done = slow && wcnt >= slow_wait;
  // read data valid only while requested, never stale
  assign mem_rdata = (mem_req && !mem_we) ? mem[mem_addr] : junk;
  assign pm_rdata = pm_ok ? pm_q : junk;
  assign io_rdata = io[io_rd_addr];
  // memories, wait counter and toggling filler
  always @(posedge clk) begin
    junk <= ~junk;
    pm_ok <= pm_req;
    pm_q <= pm_addr[7:0] ^ 8'h3c;
    wcnt <= slow ? wcnt + 4'h1 : 4'h0;
    if (mem_req && mem_we && (!slow || mem_slow_done)) begin
      mem[mem_addr] <= mem_wdata;
    end
    if (io_we) begin
      io[io_wr_addr] <= io_wdata;
    end
  end
endmodule // exec_mem_model
`default_nettype wire

// [tb/test_cpu_store_bit_flag_ops.sv]
// bench: apb and instruction sequences checked against the memory model
`timescale 1ns/100ps
`default_nettype none
`include "exec_unit_defs.vh"
module test_cpu_store_bit_flag_ops;
  logic clk = 0;
  logic rst_n = 0;
  logic psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic instr_valid = 0, instr_ready;
  logic [4:0] instr_op = 5'h00, instr_rd = 5'h00;
  logic [5:0] instr_imm = 6'h00, io_rd_addr, io_wr_addr;
  logic [2:0] instr_bit = 3'h0;
  logic mem_req, mem_we, mem_slow_done, pm_req, io_we;
  logic [15:0] mem_addr, pm_addr;
  logic [7:0] mem_wdata, mem_rdata, pm_rdata, io_rdata, io_wdata;
  logic break_pulse, sleep_pulse, wdog_pulse, irq_enable;
  logic [3:0] slow_wait = 4'h0; // model wait cycles
  int error_cnt = 0, total_checks = 0, n, p0, pulses = 0;
  // op, operand, carry in, result, flags (s and h preset)
  logic [29:0] tbl [7] = '{
    {`OP_SHL, 8'h96, 1'b0, 8'h2c, 8'h19},
    {`OP_SHR, 8'h96, 1'b0, 8'h4b, 8'h30},
    {`OP_SHR, 8'h01, 1'b0, 8'h00, 8'h3b},
    {`OP_SHRA, 8'h96, 1'b0, 8'hcb, 8'h3c},
    {`OP_RCL, 8'h96, 1'b1, 8'h2d, 8'h19},
    {`OP_RCR, 8'h96, 1'b1, 8'hcb, 8'h3c},
    {`OP_SWAP, 8'h96, 1'b1, 8'h69, 8'h31}};
  logic [4:0] ctl [4] = '{`OP_BREAK, `OP_SLEEP, `OP_WDOG, `OP_IDLE};
  cpu_store_bit_flag_ops u_cpu_store_bit_flag_ops (.clk, .rst_n, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .instr_valid, .instr_ready, .instr_op, .instr_rd, .instr_imm,
    .instr_bit, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_rdata,
    .mem_slow_done, .pm_req, .pm_addr, .pm_rdata, .io_rd_addr, .io_rdata,
    .io_we, .io_wr_addr, .io_wdata, .break_pulse, .sleep_pulse,
    .wdog_pulse, .irq_enable);
  exec_mem_model u_exec_mem_model (.clk, .mem_req, .mem_we, .mem_addr,
    .mem_wdata, .mem_rdata, .mem_slow_done, .pm_req, .pm_addr, .pm_rdata,
    .io_rd_addr, .io_rdata, .io_we, .io_wr_addr, .io_wdata, .slow_wait);
  // 40 mhz clock
  initial begin
    forever #12.5 clk = ~clk;
  end
  // count control pulses
  always @(posedge clk) begin
    pulses <= pulses + break_pulse + sleep_pulse + wdog_pulse;
  end
  task test_done;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input logic [31:0] g, e);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // bounded wait ran out
  task to;
    if (n >= 20) begin
      error_cnt++;
      $display("ERROR %0t: timeout", $time);
      test_done;
    end
  endtask
  // apb transfer: setup, access until pready, release
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk) penable <= 1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1 && n < 20);
    to;
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge clk);
  endtask
  task fl(input logic [7:0] e);
    apb(0, `ADDR_FLAGS, 0);
    chk(rd, e);
  endtask
  task zchk(input logic [15:0] e);
    apb(0, `ADDR_STATE, 0);
    chk(rd[31:16], e);
  endtask
  task wrdy;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (instr_ready !== 1 && n < 20);
    to;
  endtask
  // offer one instruction, count cycles until ready again
  task op(input logic [4:0] o, r, input logic [5:0] i,
      input logic [2:0] b, input int c);
    instr_valid <= 1;
    instr_op <= o;
    instr_rd <= r;
    instr_imm <= i;
    instr_bit <= b;
    wrdy;
    instr_valid <= 0;
    wrdy;
    chk(n, c);
  endtask
  task iochk(input logic [5:0] a, input logic [7:0] e);
    @(posedge clk);
    chk(u_exec_mem_model.io[a], e);
  endtask
  task get(input logic [4:0] r, input logic [7:0] e);
    op(`OP_IO_OUT, r, 6'h3d, 0, 1);
    iochk(6'h3d, e);
  endtask
  task ld(input logic [4:0] r, input logic [7:0] v);
    u_exec_mem_model.io[6'h3c] = v;
    op(`OP_IO_IN, r, 6'h3c, 0, 1);
  endtask
  function automatic logic [7:0] m(input logic [15:0] a);
    return u_exec_mem_model.mem[a];
  endfunction
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1;
    repeat (3) @(posedge clk);
    fl(8'h00);
    apb(0, `ADDR_SP, 0);
    chk(rd, 32'h3ff);
    apb(0, 8'h40, 0);
    chk(err, 1);
    apb(1, `ADDR_CTRL, 1);
    apb(1, `ADDR_FLAGS, 32'hff);
    $display("test done: reset");
    ld(16, 8'h81);
    ld(17, 8'h42);
    ld(30, 8'h20);
    ld(31, 8'h00);
    op(`OP_STORE_ZINC, 16, 0, 0, 1);
    zchk(16'h0021);
    chk(m(16'h0020), 8'h81);
    op(`OP_STORE_ZDEC, 17, 0, 0, 1);
    zchk(16'h0020);
    chk(m(16'h0020), 8'h42);
    op(`OP_STORE_ZDISP, 16, 6'h3f, 0, 1);
    zchk(16'h0020);
    chk(m(16'h005f), 8'h81);
    op(`OP_PM_RD, 18, 0, 0, 3);
    get(18, 8'h1c);
    op(`OP_PM_INC, 19, 0, 0, 3);
    get(19, 8'h1c);
    zchk(16'h0021);
    op(`OP_PM_R0, 5, 0, 0, 3);
    get(0, 8'h1d);
    op(`OP_PUSH, 16, 0, 0, 1);
    apb(0, `ADDR_SP, 0);
    chk(rd, 32'h3fe);
    chk(m(16'h03ff), 8'h81);
    op(`OP_POP, 20, 0, 0, 2);
    get(20, 8'h81);
    fl(8'hff);
    $display("test done: memory");
    foreach (tbl[k]) begin
      ld(21, tbl[k][24:17]);
      apb(1, `ADDR_FLAGS, 32'h30 | tbl[k][16]);
      op(tbl[k][29:25], 21, 0, 0, 1);
      get(21, tbl[k][15:8]);
      fl(tbl[k][7:0]);
    end
    $display("test done: shifts");
    apb(1, `ADDR_FLAGS, 32'h55);
    u_exec_mem_model.io[3] = 8'h5a;
    op(`OP_IO_SET, 0, 3, 0, 1);
    iochk(3, 8'h5b);
    op(`OP_IO_CLR, 0, 3, 6, 1);
    iochk(3, 8'h1b);
    op(`OP_BIT_TO_T, 16, 0, 1, 1);
    fl(8'h15);
    op(`OP_BIT_TO_T, 16, 0, 7, 1);
    op(`OP_T_TO_BIT, 17, 0, 0, 1);
    get(17, 8'h43);
    fl(8'h55);
    apb(1, `ADDR_FLAGS, 0);
    for (int s = 0; s < 8; s++) begin
      op(`OP_FLAG_SET, 0, 0, s[2:0], 1);
      fl(8'h01 << s);
      chk(irq_enable, s == 7);
      op(`OP_FLAG_CLR, 0, 0, s[2:0], 1);
      fl(8'h00);
    end
    $display("test done: bits and flags");
    apb(1, `ADDR_FLAGS, 32'h5a);
    p0 = pulses;
    foreach (ctl[k]) op(ctl[k], 0, 0, 0, 1);
    chk(pulses - p0, 3);
    fl(8'h5a);
    ld(31, 8'h10);
    for (int w = 0; w < 5; w += 4) begin
      slow_wait <= w[3:0];
      u_exec_mem_model.mem[16'h1021] = 8'h00;
      op(`OP_STORE_Z, 16, 0, 0, w + 2);
      zchk(16'h1021);
      chk(m(16'h1021), 8'h81);
    end
    $display("test done: control and slow store");
    test_done;
  end
endmodule // test_cpu_store_bit_flag_ops
`default_nettype wire
